//--- rtl/dpw_pkg.sv
// Constants for the page-mode DRAM write timing controller.
// Assumes a 25 MHz system clock shared with the processor bus.
package dpw_pkg;
    localparam int unsigned ROW_BITS      = 22;  // Upper address bits of a page
    localparam int unsigned ADDR_BITS     = 32;
    localparam logic [3:0]  ACK_READ      = 4'h4; // Single read latency
    localparam logic [3:0]  ACK_BLOCK     = 4'h7; // Block refill latency
    localparam logic [3:0]  ACK_WRITE     = 4'h3; // First write latency
    localparam logic [3:0]  ACK_PAGE      = 4'h2; // Page write latency
    localparam logic [3:0]  REFRESH_LEN   = 4'h4; // Refresh cycle length
    localparam logic [3:0]  CNT_RST       = 4'h0;

    // Controller states
    typedef enum logic [2:0] {
        DPW_IDLE     = 3'b000,
        DPW_ACCESS   = 3'b001,
        DPW_IDLE_RAS = 3'b010,
        DPW_PRECHG   = 3'b011,
        DPW_REFRESH  = 3'b100
    } dpw_state_t;

    // Access kinds
    typedef enum logic [2:0] {
        DPW_K_READ   = 3'b000,
        DPW_K_BLOCK  = 3'b001,
        DPW_K_WRITE  = 3'b010,
        DPW_K_PAGE   = 3'b011,
        DPW_K_REF    = 3'b100
    } dpw_kind_t;
endpackage

//--- rtl/dpw_cycle_cnt.sv
// Cycle counter that times one external access.
// Assumes the controller clears it at the start of every access.
`timescale 1ns/1ps
module dpw_cycle_cnt (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_ce,
    input  wire logic       i_clear,
    input  wire logic       i_run,
    output logic [3:0]      o_count
);
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;

    // Clear wins over run; the counter saturates rather than wrapping
    assign nxt_cnt = i_clear ? dpw_pkg::CNT_RST :
                     (i_run && cnt_ff != 4'hF) ? cnt_ff + 4'h1 : cnt_ff;

    // Counter register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cnt_ff <= dpw_pkg::CNT_RST;
        end else if (i_ce) begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign o_count = cnt_ff;
endmodule

//--- rtl/dpw_ctrl.sv
// Page-mode DRAM access sequencer with open-row page writes.
// Assumes bus strobes are synchronous to i_clk; refresh request is a
// level held until acknowledged.
// Functional notes
// - Write with near-write hint counts as page write on same upper 22 bits
// - Page write reuses the open row and skips row activation
// - Page write acknowledge comes 2 cycles after access start
// - Non-page access from open-row idle first precharges RAS high
// - Single read acknowledge comes 4 cycles after access start
// - Block refill read acknowledge comes 7 cycles after access start
// - First write acknowledge comes 3 cycles after access start
// - After any write, idle with RAS kept asserted
// - Open-row idle takes page write on hinted same-row write, leaves on any other request, else stays
`timescale 1ns/1ps
module dpw_ctrl (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_ce,
    input  wire logic        i_cs,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic        i_burst,
    input  wire logic        i_near_write_hint,
    input  wire logic        i_ref_req,
    input  wire logic [31:0] i_addr,
    output logic             o_ack,
    output logic             o_ras_n,
    output logic             o_cas_n,
    output logic             o_ref_ack,
    output logic [2:0]       o_kind
);
    dpw_pkg::dpw_state_t state_ff, nxt_state;
    dpw_pkg::dpw_kind_t  kind_ff, nxt_kind;
    logic [dpw_pkg::ROW_BITS-1:0] row_ff;
    logic                row_ok_ff;
    logic                ack_ff, ras_n_ff, cas_n_ff, ref_ack_ff;
    logic [3:0]          count;
    logic                cnt_clear, cnt_run;

    // Latency for each kind; used by both ack and end detection
    function automatic logic [3:0] ack_at(input dpw_pkg::dpw_kind_t k);
        unique case (k)
            dpw_pkg::DPW_K_READ:  ack_at = dpw_pkg::ACK_READ;
            dpw_pkg::DPW_K_BLOCK: ack_at = dpw_pkg::ACK_BLOCK;
            dpw_pkg::DPW_K_WRITE: ack_at = dpw_pkg::ACK_WRITE;
            dpw_pkg::DPW_K_PAGE:  ack_at = dpw_pkg::ACK_PAGE;
            dpw_pkg::DPW_K_REF:   ack_at = dpw_pkg::REFRESH_LEN;
            default:              ack_at = dpw_pkg::ACK_READ;
        endcase
    endfunction

    // Request decode
    wire rd_req  = i_cs & i_rd;
    wire wr_req  = i_cs & i_wr;
    wire any_req = rd_req | wr_req | i_ref_req;
    wire same_row = row_ok_ff &&
        (i_addr[31 -: dpw_pkg::ROW_BITS] == row_ff);
    // Hint is trusted only when the held row really matches
    wire page_hit = wr_req & i_near_write_hint & same_row & ~i_ref_req;
    wire dpw_pkg::dpw_kind_t req_kind =
        i_ref_req ? dpw_pkg::DPW_K_REF :
        rd_req    ? (i_burst ? dpw_pkg::DPW_K_BLOCK : dpw_pkg::DPW_K_READ) :
                    dpw_pkg::DPW_K_WRITE;
    // Count 0 is the first access cycle; ack stands in the cycle where the
    // count reaches N, that is N edges after RAS fell for the access
    wire at_end   = (count == ack_at(kind_ff));
    wire is_write = (kind_ff == dpw_pkg::DPW_K_WRITE) ||
                    (kind_ff == dpw_pkg::DPW_K_PAGE);

    // Next-state selection
    always_comb begin
        nxt_state = state_ff;
        nxt_kind  = kind_ff;
        cnt_clear = 1'b0;
        unique case (state_ff)
            dpw_pkg::DPW_IDLE: begin
                cnt_clear = 1'b1;
                if (any_req) begin
                    nxt_state = (req_kind == dpw_pkg::DPW_K_REF) ?
                        dpw_pkg::DPW_REFRESH : dpw_pkg::DPW_ACCESS;
                    nxt_kind  = req_kind;
                end
            end
            dpw_pkg::DPW_IDLE_RAS: begin
                cnt_clear = 1'b1;
                if (page_hit) begin
                    nxt_state = dpw_pkg::DPW_ACCESS;
                    nxt_kind  = dpw_pkg::DPW_K_PAGE;
                end else if (any_req) begin
                    nxt_state = dpw_pkg::DPW_PRECHG;
                    nxt_kind  = req_kind;
                end
            end
            dpw_pkg::DPW_PRECHG: begin
                cnt_clear = 1'b1;
                nxt_state = (kind_ff == dpw_pkg::DPW_K_REF) ?
                    dpw_pkg::DPW_REFRESH : dpw_pkg::DPW_ACCESS;
            end
            dpw_pkg::DPW_ACCESS: begin
                if (at_end) begin
                    cnt_clear = 1'b1;
                    nxt_state = is_write ? dpw_pkg::DPW_IDLE_RAS
                                         : dpw_pkg::DPW_IDLE;
                end
            end
            dpw_pkg::DPW_REFRESH: begin
                if (at_end) begin
                    cnt_clear = 1'b1;
                    nxt_state = dpw_pkg::DPW_IDLE;
                end
            end
            default: nxt_state = dpw_pkg::DPW_IDLE;
        endcase
    end

    assign cnt_run = (state_ff == dpw_pkg::DPW_ACCESS) ||
                     (state_ff == dpw_pkg::DPW_REFRESH);

    dpw_cycle_cnt u_cnt (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_clear   (cnt_clear),
        .i_run     (cnt_run),
        .o_count   (count)
    );

    // Pin-level next values; RAS stays low across open-row idle
    wire nxt_ras_n = ~((nxt_state == dpw_pkg::DPW_ACCESS) ||
                       (nxt_state == dpw_pkg::DPW_REFRESH) ||
                       (nxt_state == dpw_pkg::DPW_IDLE_RAS));
    wire nxt_cas_n = ~(cnt_run && !cnt_clear && count != 4'h0);
    wire nxt_ack   = (state_ff == dpw_pkg::DPW_ACCESS) &&
                     (count == ack_at(kind_ff) - 4'h1);
    // Raised in the last refresh cycle, like ack, so a level request that
    // is dropped on seeing it is not taken a second time from idle
    wire nxt_ref_ack = (state_ff == dpw_pkg::DPW_REFRESH) &&
                       (count == dpw_pkg::REFRESH_LEN - 4'h1);
    // Row is captured when a first write opens it
    wire open_row  = (state_ff == dpw_pkg::DPW_ACCESS) && at_end &&
                     (kind_ff == dpw_pkg::DPW_K_WRITE);
    wire close_row = (nxt_state == dpw_pkg::DPW_PRECHG) ||
                     (nxt_state == dpw_pkg::DPW_IDLE);

    // State register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_ff <= dpw_pkg::DPW_IDLE;
            kind_ff  <= dpw_pkg::DPW_K_READ;
        end else if (i_ce) begin
            state_ff <= nxt_state;
            kind_ff  <= nxt_kind;
        end
    end

    // Open row tracking
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            row_ff    <= '0;
            row_ok_ff <= 1'b0;
        end else if (i_ce) begin
            if (state_ff != dpw_pkg::DPW_IDLE_RAS &&
                nxt_state == dpw_pkg::DPW_ACCESS && req_kind ==
                dpw_pkg::DPW_K_WRITE) begin
                row_ff <= i_addr[31 -: dpw_pkg::ROW_BITS];
            end
            if (open_row) begin
                row_ok_ff <= 1'b1;
            end else if (close_row) begin
                row_ok_ff <= 1'b0;
            end
        end
    end

    // Output registers
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ack_ff     <= 1'b0;
            ras_n_ff   <= 1'b1;
            cas_n_ff   <= 1'b1;
            ref_ack_ff <= 1'b0;
        end else if (i_ce) begin
            ack_ff     <= nxt_ack;
            ras_n_ff   <= nxt_ras_n;
            cas_n_ff   <= nxt_cas_n;
            ref_ack_ff <= nxt_ref_ack;
        end
    end

    assign o_ack     = ack_ff;
    assign o_ras_n   = ras_n_ff;
    assign o_cas_n   = cas_n_ff;
    assign o_ref_ack = ref_ack_ff;
    assign o_kind    = kind_ff;

    // Cycles since the access started, for checking ack latency
    logic [3:0] chk_cnt_ff;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            chk_cnt_ff <= 4'h0;
        end else if (i_ce) begin
            chk_cnt_ff <= (state_ff == dpw_pkg::DPW_ACCESS) ?
                          chk_cnt_ff + 4'h1 : 4'h0;
        end
    end

    a_page_ack_two: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (o_ack && kind_ff == dpw_pkg::DPW_K_PAGE && i_ce) |->
        chk_cnt_ff == 4'h2)
        else $error("page write ack latency wrong");
    a_read_ack_four: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (o_ack && kind_ff == dpw_pkg::DPW_K_READ && i_ce) |->
        chk_cnt_ff == 4'h4)
        else $error("single read ack latency wrong");
    a_block_ack_seven: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (o_ack && kind_ff == dpw_pkg::DPW_K_BLOCK && i_ce) |->
        chk_cnt_ff == 4'h7)
        else $error("block read ack latency wrong");
    a_write_ack_three: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (o_ack && kind_ff == dpw_pkg::DPW_K_WRITE && i_ce) |->
        chk_cnt_ff == 4'h3)
        else $error("first write ack latency wrong");
    a_idle_ras_low: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (state_ff == dpw_pkg::DPW_IDLE_RAS) |-> !o_ras_n)
        else $error("RAS not held in open-row idle");
    a_precharge_high: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (state_ff == dpw_pkg::DPW_PRECHG) |-> o_ras_n)
        else $error("RAS not precharged");
    a_page_entry: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (state_ff == dpw_pkg::DPW_IDLE_RAS && page_hit && i_ce) |=>
        state_ff == dpw_pkg::DPW_ACCESS && kind_ff == dpw_pkg::DPW_K_PAGE)
        else $error("page write not entered");
    a_page_same_row: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (state_ff == dpw_pkg::DPW_IDLE_RAS && wr_req && i_near_write_hint &&
         !same_row && i_ce) |=> state_ff == dpw_pkg::DPW_PRECHG)
        else $error("mismatched row taken as page write");
    a_page_no_activate: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (state_ff == dpw_pkg::DPW_ACCESS && kind_ff == dpw_pkg::DPW_K_PAGE)
        |-> !o_ras_n && !$past(o_ras_n))
        else $error("page write reactivated row");
    a_prechg_continue: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (state_ff == dpw_pkg::DPW_PRECHG && i_ce) |=>
        state_ff inside {dpw_pkg::DPW_ACCESS, dpw_pkg::DPW_REFRESH})
        else $error("precharge did not continue");

    c_page_write: cover property (@(posedge i_clk)
        o_ack && kind_ff == dpw_pkg::DPW_K_PAGE);
    c_block_read: cover property (@(posedge i_clk)
        o_ack && kind_ff == dpw_pkg::DPW_K_BLOCK);
    c_precharge: cover property (@(posedge i_clk)
        state_ff == dpw_pkg::DPW_PRECHG);
endmodule

//--- tb/dpw_dram_model.sv
// Behavioural DRAM array watcher that counts row activations.
// Assumes RAS comes registered on the same clock as the controller.
`timescale 1ns/1ps
module dpw_dram_model (
    input  wire logic   i_clk,
    input  wire logic   i_ras_n,
    output logic [15:0] o_act_count
);
    logic        ras_n_ff = 1'b1;
    logic [15:0] act_ff   = 16'h0000;

    // A falling RAS opens a row; an unknown level counts as nothing
    always @(posedge i_clk) begin
        ras_n_ff <= i_ras_n;
        if (ras_n_ff === 1'b1 && i_ras_n === 1'b0) begin
            act_ff <= act_ff + 16'h0001;
        end
    end

    assign o_act_count = act_ff;
endmodule

//--- tb/dram_page_write_timing_control_tb_top.sv
// Self-checking bench for the page-mode DRAM access sequencer.
// Assumes the sequencer and the row-activation watcher share one clock.
`timescale 1ns/1ps
module dram_page_write_timing_control_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cs = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        bu = 1'b0;
    logic        hint = 1'b0;
    logic        ref_req = 1'b0;
    logic [31:0] addr = 32'h0000_0000;
    logic        ack;
    logic        ras_n;
    logic        cas_n;
    logic        ref_ack;
    logic [2:0]  kind;
    logic [15:0] acts;
    logic [15:0] a0;
    int          fail_count = 0;
    int          num_checks = 0;

    dpw_ctrl i_dut (.i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_cs(cs),
        .i_rd(rd), .i_wr(wr), .i_burst(bu), .i_near_write_hint(hint),
        .i_ref_req(ref_req), .i_addr(addr), .o_ack(ack), .o_ras_n(ras_n),
        .o_cas_n(cas_n), .o_ref_ack(ref_ack), .o_kind(kind));
    dpw_dram_model i_mem (.i_clk(clk), .i_ras_n(ras_n), .o_act_count(acts));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Holds the strobes until ack is seen, then drops them. RAS falls on the
    // edge that takes the request and ack rises lat edges later; ack is read as
    // sampled at the edge, so it shows one cycle after it rose
    task automatic access(input logic r, w, b, h, input logic [31:0] a,
                          input logic [3:0] lat, input logic pre,
                          input logic [2:0] k);
        int n;
        n = 0;
        cs <= 1'b1; rd <= r; wr <= w; bu <= b; hint <= h; addr <= a;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) check(32'h0, 32'h1);
        if (n >= 20) summarize();
        check(32'(n), 32'(lat) + 32'(pre) + 32'h2);
        check(32'(kind), 32'(k));
        check(32'(cas_n), 32'h0);
        cs <= 1'b0; rd <= 1'b0; wr <= 1'b0; bu <= 1'b0; hint <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_reads;
        access(1, 0, 0, 0, 32'h0000_1000, dpw_pkg::ACK_READ, 0, 3'h0);
        check(32'(ras_n), 32'h1);
        check(32'(cas_n), 32'h1);
        access(1, 0, 1, 0, 32'h0000_2000, dpw_pkg::ACK_BLOCK, 0, 3'h1);
        $display("test reads done");
    endtask

    task automatic t_writes;
        access(0, 1, 0, 0, 32'h0001_2400, dpw_pkg::ACK_WRITE, 0, 3'h2);
        repeat (3) @(posedge clk);
        check(32'(ras_n), 32'h0);
        a0 = acts;
        // Bit 9 lies below the page field, so this still matches
        access(0, 1, 0, 1, 32'h0001_2600, dpw_pkg::ACK_PAGE, 0, 3'h3);
        check(32'(acts), 32'(a0));
        // Bit 10 is the lowest page bit: hint alone must not page
        access(0, 1, 0, 1, 32'h0001_2000, dpw_pkg::ACK_WRITE, 1, 3'h2);
        access(0, 1, 0, 0, 32'h0001_2000, dpw_pkg::ACK_WRITE, 1, 3'h2);
        access(1, 0, 0, 0, 32'h0001_2000, dpw_pkg::ACK_READ, 1, 3'h0);
        // Three non-page accesses each precharge and open the row again
        check(32'(acts), 32'(a0) + 32'h3);
        $display("test writes done");
    endtask

    task automatic t_refresh;
        int n;
        n = 0;
        access(0, 1, 0, 0, 32'h0003_0000, dpw_pkg::ACK_WRITE, 0, 3'h2);
        ref_req <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (ref_ack !== 1'b1 && n < 20);
        ref_req <= 1'b0;
        check(32'(n < 20), 32'h1);
        if (n >= 20) summarize();
        @(posedge clk);
        access(0, 1, 0, 1, 32'h0003_0000, dpw_pkg::ACK_WRITE, 0, 3'h2);
        $display("test refresh done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reads();
        t_writes();
        t_refresh();
        summarize();
    end
endmodule
